// ---- pkg/pbc_pkg.sv ----
// Constants shared by the secondary bus power and clock controller.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.

package pbc_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int PBC_CLK_PERIOD_NS = 50;
	// Least time the secondary bus must read idle before leaving B0
	localparam int PBC_IDLE_SETTLE_NS = 500;
	localparam int PBC_IDLE_SETTLE_CYC =
		(PBC_IDLE_SETTLE_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;
	// Least time with no clock edge before the clock counts as stopped
	localparam int PBC_CLK_QUIET_NS = 2000;
	localparam int PBC_CLK_QUIET_CYC =
		(PBC_CLK_QUIET_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;
	// Cycles after reset release before the straps are caught
	localparam logic [1:0] PBC_STRAP_WAIT = 2'h3;

	// ****************************************************************
	// Register map: indices, byte address is four times the index
	// ****************************************************************
	localparam int PBC_CAP_IDX = 2;
	localparam int PBC_CSR_IDX = 4;
	localparam int PBC_BSE_IDX = 6;
	localparam int PBC_STAT_IDX = 8;
	localparam logic [7:0] PBC_CAP_ADDR = 8'(PBC_CAP_IDX * 4);
	localparam logic [7:0] PBC_CSR_ADDR = 8'(PBC_CSR_IDX * 4);
	localparam logic [7:0] PBC_BSE_ADDR = 8'(PBC_BSE_IDX * 4);
	localparam logic [7:0] PBC_STAT_ADDR = 8'(PBC_STAT_IDX * 4);

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int PBC_CAP_D2_BIT = 10;
	localparam int PBC_CSR_PS_LSB = 0;
	localparam int PBC_BSE_SEL_BIT = 6;
	localparam int PBC_BSE_EN_BIT = 7;
	localparam int PBC_STAT_BUS_LSB = 0;
	localparam int PBC_STAT_CLKRUN_BIT = 4;
	localparam int PBC_STAT_VCC_BIT = 5;
	localparam int PBC_STAT_M66_BIT = 6;
	localparam int PBC_STAT_PLOST_BIT = 7;
	localparam int PBC_STAT_IDLE_BIT = 8;
	localparam logic PBC_EN_RESET = 1'b1;

	typedef enum logic [1:0] {
		PBC_D0 = 2'b00,
		PBC_D1 = 2'b01,
		PBC_D2 = 2'b10,
		PBC_D3HOT = 2'b11
	} pbc_dstate_t;

	typedef enum logic [2:0] {
		PBC_B0 = 3'b000,
		PBC_B1 = 3'b001,
		PBC_B2 = 3'b010,
		PBC_B3 = 3'b011,
		PBC_SETTLE = 3'b100
	} pbc_bus_t;

endpackage

// ---- verification/pbc_bus_power_ctrl_tb_top.sv ----
// Self-checking bench of the secondary bus power and clock controller.
// Assumes the clock source model beside it and APB timing per hand-over.

`timescale 1ns/100ps
`default_nettype none

module pbc_bus_power_ctrl_tb_top import pbc_pkg::*; ;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic pm66 = 1'b0;
	logic sm66 = 1'b0;
	logic idle = 1'b1;
	logic plost = 1'b0;
	logic b3s = 1'b0;
	logic d2s = 1'b0;
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic sclk;
	wire logic stop;
	wire logic vcc;
	wire logic [2:0] bst;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic er;

	always #25 clk = ~clk;

	// Short settle and quiet counts keep the run brief
	pbc_bus_power_ctrl #(.IDLE_SETTLE_CYC(2), .CLK_QUIET_CYC(8))
		pbc_bus_power_ctrl_i (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SEC_CLK(sclk), .SEC_M66EN(sm66),
		.PRI_M66EN(pm66), .SEC_BUS_IDLE(idle), .PWR_LOST(plost),
		.B3_SUPPORT_STRAP(b3s), .LIGHT_SLEEP2_SUPPORTED_STRAP(d2s),
		.SEC_CLK_STOP(stop), .SEC_VCC_EN(vcc), .BUS_STATE(bst));

	pbc_sec_clk_model pbc_sec_clk_model_i (.stop_req(stop), .vcc_en(vcc),
		.sec_clk(sclk));

	// ****************************************************************
	// Reporting
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// APB master and helpers
	// ****************************************************************
	// Ready is read at the rising edge, before the slave's registers
	// move, so the request stands until the edge that completes it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_mismatch++;
				give_verdict();
			end
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'h1);
	endtask

	task automatic rdreg(input logic [7:0] a);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask

	task automatic do_reset(input logic [3:0] straps);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		// Speed pins and straps change only while reset is held
		{d2s, pm66, sm66, b3s} <= straps;
		repeat (11) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task automatic wait_bus(input logic [2:0] e);
		int n;
		n = 0;
		while (bst !== e && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (bst !== e) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// ****************************************************************
	// Expected values
	// ****************************************************************
	function automatic logic [2:0] exp_bus(input logic [1:0] d);
		case (d)
			2'h0: exp_bus = PBC_B0;
			2'h1: exp_bus = PBC_B1;
			2'h2: exp_bus = PBC_B2;
			default: exp_bus = b3s ? PBC_B3 : PBC_B2;
		endcase
	endfunction

	function automatic logic [31:0] exp_stat(input logic [2:0] st,
		input logic en);
		logic stp;
		logic v;
		stp = en && (st == PBC_B2 || st == PBC_B3);
		v = !(en && st == PBC_B3) && !plost;
		exp_stat = {23'h0, idle, plost, sm66, v, !stp && v, 1'b0, st};
	endfunction

	task automatic check_all(input logic [2:0] st, input logic en);
		wait_bus(st);
		// Long enough for the stop to land and the quiet count to run
		repeat (30) @(posedge clk);
		chk(stop, en && (st == PBC_B2 || st == PBC_B3));
		chk(vcc, !(en && st == PBC_B3) && !plost);
		rdreg(PBC_STAT_ADDR);
		chk(rd, exp_stat(st, en));
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [1:0] d;
		d = 2'($urandom(32'h1E62D4C4));
		do_reset(4'h0);
		chk(bst, PBC_B0);
		rdreg(PBC_BSE_ADDR);
		chk(rd[7], 1'b1);
		rdreg(PBC_CSR_ADDR);
		chk(rd, 32'h0);
		rdreg(8'h3C);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("test reset and map done");
		for (int i = 0; i < 16; i++) begin
			do_reset(4'(i));
			rdreg(PBC_CAP_ADDR);
			chk(rd[10], d2s && !sm66);
			wr(PBC_BSE_ADDR, 32'hC0);
			rdreg(PBC_BSE_ADDR);
			chk(rd[6], !(pm66 && sm66) && !b3s);
			wr(PBC_CSR_ADDR, 32'h3);
			check_all(exp_bus(2'h3), 1'b1);
		end
		$display("test straps done");
		// 33 MHz segment from here on, so B2 is allowed
		do_reset(4'h9);
		idle <= 1'b0;
		wr(PBC_CSR_ADDR, 32'h0);
		check_all(PBC_B0, 1'b1);
		wr(PBC_CSR_ADDR, 32'h1);
		repeat (10) @(posedge clk);
		chk(bst, PBC_SETTLE);
		idle <= 1'b1;
		check_all(PBC_B1, 1'b1);
		$display("test idle settle done");
		for (int i = 0; i < 12; i++) begin
			d = (i < 4) ? 2'(i) : 2'($urandom());
			wr(PBC_CSR_ADDR, {30'h0, d});
			check_all(exp_bus(d), 1'b1);
			// Only bridge registers are touched, never a bus function
			rdreg(PBC_CSR_ADDR);
			chk(rd, {30'h0, d});
		end
		apb(1'b1, PBC_CSR_ADDR, {30'h0, ~d}, 4'h0);
		rdreg(PBC_CSR_ADDR);
		chk(rd, {30'h0, d});
		$display("test mapping done");
		wr(PBC_BSE_ADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(PBC_CSR_ADDR, i);
			check_all(exp_bus(2'(i)), 1'b0);
		end
		$display("test enable off done");
		wr(PBC_BSE_ADDR, 32'h80);
		wr(PBC_CSR_ADDR, 32'h0);
		check_all(PBC_B0, 1'b1);
		plost <= 1'b1;
		check_all(PBC_B3, 1'b1);
		plost <= 1'b0;
		// Supply back: the system resets the segment
		do_reset(4'h9);
		chk(bst, PBC_B0);
		chk(vcc, 1'b1);
		$display("test power loss done");
		give_verdict();
	end
endmodule

`default_nettype wire

// ---- verification/pbc_sec_clk_model.sv ----
// Bench model of the external clock source of the secondary bus.
// Assumes the stop request and supply enable are levels from the block.

`timescale 1ns/100ps
`default_nettype none

module pbc_sec_clk_model (
	// Control from the controller
	input wire logic stop_req,
	input wire logic vcc_en,
	// Clock back to the controller
	output logic sec_clk
);
	// ****************************************************************
	// Clock source, 400 ns period
	// ****************************************************************
	// Odd start offset keeps it unrelated in phase to the system clock
	initial begin
		sec_clk = 1'b0;
		#137;
		forever begin
			#200;
			// Stop request parks it low; no supply means no clock
			if (stop_req || !vcc_en) begin
				sec_clk = 1'b0;
			end else begin
				sec_clk = ~sec_clk;
			end
		end
	end
endmodule

`default_nettype wire

// ---- verilog/pbc_bus_power_ctrl.sv ----
// Secondary bus power and clock controller of a bridge, with APB slave.
// Assumes an external clock source obeying the stop request and a
// supply switch obeying the Vcc enable; secondary bus pins and straps are asynchronous.
//
// Functional notes
// - Reset always returns the secondary bus to B0.
// - Power loss forces B3; other changes only by power state writes.
// - B3 on D3hot is optional, chosen by a strap.
// - Clock is controlled by sideband stop request to external source.
// - Above 33 MHz the clock frequency never changes outside reset; the code still stops the clock in B2 and B3 on a 66 MHz segment.
// - Light_sleep2_supported capability bit reads zero on a 66 MHz segment.
// - HOT_OFF_BUS_STATE_SELECT select bit reads zero when both segments run 66 MHz.
// - Enable cleared by software means no clock stop in D2 or D3hot.
// - High 66 MHz enable input means the segment runs at 66 MHz.
// - Bus state follows the bridge power state field, read and write.
// - D0 to B0, D1 to B1, D2 to B2 with clock stop, D3cold to B3.
// - D3hot stops clock; removes supply when B3 applies, else B2.
// - Read-only HOT_OFF_BUS_STATE_SELECT select bit tells the D3hot bus state, save on a 66/66 bridge without the B3 strap (reads zero, goes B2).
// - Enable bit cleared leaves power and clock to other mechanism.
// - In B2 the clock stops low while supply stays on.
// - Leave B0 only after the bus has settled idle.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.

`timescale 1ns/100ps
`default_nettype none

module pbc_bus_power_ctrl
	import pbc_pkg::*;
#(
	parameter int IDLE_SETTLE_CYC = PBC_IDLE_SETTLE_CYC,
	parameter int CLK_QUIET_CYC = PBC_CLK_QUIET_CYC
) (
	// System
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Secondary bus pins and straps
	input wire logic SEC_CLK,
	input wire logic SEC_M66EN,
	input wire logic PRI_M66EN,
	input wire logic SEC_BUS_IDLE,
	input wire logic PWR_LOST,
	input wire logic B3_SUPPORT_STRAP,
	input wire logic LIGHT_SLEEP2_SUPPORTED_STRAP,
	// Power and clock control
	output logic SEC_CLK_STOP,
	output logic SEC_VCC_EN,
	output logic [2:0] BUS_STATE
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		pbc_dstate_t power_state_field;
		logic bus_power_clock_ctrl_enable;
		logic b3_supported;
		logic d2_strap;
		logic [1:0] strap_cnt;
		logic strap_done;
		pbc_bus_t bus;
		logic clk_prev;
		logic clk_stop;
		logic vcc_en;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pbc_state_t;

	pbc_state_t s_reg;
	pbc_state_t s_next;

	logic [6:0] pins_sync;
	logic clk_s;
	logic m66_sec;
	logic m66_pri;
	logic idle_s;
	logic pwr_lost_s;
	logic b3_strap_s;
	logic d2_strap_s;
	logic idle_done;
	logic clk_quiet;
	logic clk_edge;
	logic m66_both;
	logic hot_off_bus_state_select;
	logic light_sleep2_supported;
	logic apb_access;
	logic apb_done;
	logic wr_csr;
	logic wr_bse;
	pbc_bus_t target;

	initial begin
		if (IDLE_SETTLE_CYC < 1 || CLK_QUIET_CYC < 2) begin
			$error("pbc_bus_power_ctrl: timer counts too small");
		end
	end

	// ****************************************************************
	// Pin synchronisers and timers
	// ****************************************************************
	pbc_sync #(
		.WIDTH(7)
	) u_sync (
		.clk(CLOCK),
		.rst(SYS_RST),
		.d({LIGHT_SLEEP2_SUPPORTED_STRAP, B3_SUPPORT_STRAP, PWR_LOST, SEC_BUS_IDLE,
			PRI_M66EN, SEC_M66EN, SEC_CLK}),
		.q(pins_sync)
	);

	assign clk_s = pins_sync[0];
	assign m66_sec = pins_sync[1];
	assign m66_pri = pins_sync[2];
	assign idle_s = pins_sync[3];
	assign pwr_lost_s = pins_sync[4];
	assign b3_strap_s = pins_sync[5];
	assign d2_strap_s = pins_sync[6];

	// Idle must hold unbroken; a single busy cycle restarts the wait
	pbc_hold_timer #(
		.COUNT(IDLE_SETTLE_CYC)
	) u_idle (
		.clk(CLOCK),
		.rst(SYS_RST),
		.cond(idle_s),
		.done(idle_done)
	);

	assign clk_edge = clk_s ^ s_reg.clk_prev;

	pbc_hold_timer #(
		.COUNT(CLK_QUIET_CYC)
	) u_quiet (
		.clk(CLOCK),
		.rst(SYS_RST),
		.cond(!clk_edge),
		.done(clk_quiet)
	);

	// ****************************************************************
	// Capability and select bits
	// ****************************************************************
	assign m66_both = m66_sec && m66_pri;
	// 66 MHz clocking forbids a stopped clock, so D2 is hidden
	assign light_sleep2_supported = s_reg.d2_strap && !m66_sec;
	// Zero selects B3 on D3hot when the B3 strap is set; forced to zero on a 66/66 bridge
	assign hot_off_bus_state_select =
		!m66_both && !s_reg.b3_supported;

	function automatic pbc_bus_t map_state(input pbc_dstate_t ps,
		input logic sel, input logic b3ok);
		case (ps)
			PBC_D0: map_state = PBC_B0;
			PBC_D1: map_state = PBC_B1;
			PBC_D2: map_state = PBC_B2;
			PBC_D3HOT: map_state = (!sel && b3ok) ? PBC_B3 : PBC_B2;
			default: map_state = PBC_B0;
		endcase
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] addr,
		input pbc_state_t st, input logic d2cap, input logic sel,
		input logic run, input logic m66, input logic plost,
		input logic idl);
		logic [31:0] w;
		w = '0;
		case (addr)
			PBC_CAP_ADDR: w[PBC_CAP_D2_BIT] = d2cap;
			PBC_CSR_ADDR: w[PBC_CSR_PS_LSB +: 2] = st.power_state_field;
			PBC_BSE_ADDR: begin
				w[PBC_BSE_SEL_BIT] = sel;
				w[PBC_BSE_EN_BIT] = st.bus_power_clock_ctrl_enable;
			end
			PBC_STAT_ADDR: begin
				w[PBC_STAT_BUS_LSB +: 3] = st.bus;
				w[PBC_STAT_CLKRUN_BIT] = run;
				w[PBC_STAT_VCC_BIT] = st.vcc_en;
				w[PBC_STAT_M66_BIT] = m66;
				w[PBC_STAT_PLOST_BIT] = plost;
				w[PBC_STAT_IDLE_BIT] = idl;
			end
			default: w = '0;
		endcase
		read_word = w;
	endfunction

	function automatic logic addr_mapped(input logic [7:0] addr);
		addr_mapped = (addr == PBC_CAP_ADDR) || (addr == PBC_CSR_ADDR) ||
			(addr == PBC_BSE_ADDR) || (addr == PBC_STAT_ADDR);
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// One wait state: pready rises the cycle after the access phase opens
	assign apb_access = PSEL && PENABLE;
	assign apb_done = apb_access && s_reg.pready;
	assign wr_csr = apb_done && PWRITE && PSTRB[0] &&
		(PADDR == PBC_CSR_ADDR);
	assign wr_bse = apb_done && PWRITE && PSTRB[0] &&
		(PADDR == PBC_BSE_ADDR);
	assign target = map_state(s_reg.power_state_field,
		hot_off_bus_state_select, s_reg.b3_supported);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		s_next.clk_prev = clk_s;

		// Straps are caught once the synchroniser has settled
		if (!s_reg.strap_done) begin
			if (s_reg.strap_cnt == PBC_STRAP_WAIT) begin
				s_next.strap_done = 1'b1;
				s_next.b3_supported = b3_strap_s;
				s_next.d2_strap = d2_strap_s;
			end else begin
				s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
			end
		end

		// Register writes
		if (wr_csr) begin
			s_next.power_state_field =
				pbc_dstate_t'(PWDATA[PBC_CSR_PS_LSB +: 2]);
		end
		if (wr_bse) begin
			s_next.bus_power_clock_ctrl_enable =
				PWDATA[PBC_BSE_EN_BIT];
		end

		// APB answer
		s_next.pready = apb_access && !s_reg.pready;
		s_next.pslverr = 1'b0;
		if (apb_access && !s_reg.pready) begin
			s_next.pslverr = !addr_mapped(PADDR);
			s_next.prdata = PWRITE ? 32'h0000_0000 :
				read_word(PADDR, s_reg, light_sleep2_supported,
				hot_off_bus_state_select, !clk_quiet, m66_sec,
				pwr_lost_s, idle_s);
		end

		// Bus state sequencing
		if (pwr_lost_s) begin
			s_next.bus = PBC_B3;
		end else begin
			case (s_reg.bus)
				PBC_B0: begin
					if (target != PBC_B0) begin
						s_next.bus = PBC_SETTLE;
					end
				end
				PBC_SETTLE: begin
					if (target == PBC_B0) begin
						s_next.bus = PBC_B0;
					end else if (idle_done) begin
						s_next.bus = target;
					end
				end
				PBC_B1, PBC_B2, PBC_B3: begin
					s_next.bus = target;
				end
				default: s_next.bus = PBC_B0;
			endcase
		end

		// Actions; with the enable cleared nothing is stopped or removed, save the supply on power loss
		s_next.vcc_en = !pwr_lost_s && !(s_reg.bus_power_clock_ctrl_enable
			&& s_next.bus == PBC_B3);
		if (!s_reg.bus_power_clock_ctrl_enable ||
			s_next.bus == PBC_B0 || s_next.bus == PBC_B1 ||
			s_next.bus == PBC_SETTLE) begin
			s_next.clk_stop = 1'b0;
		end else if (!clk_s) begin
			// Asserted only in the low phase so the clock parks low
			s_next.clk_stop = 1'b1;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// The clock rate itself is never touched; only a stop is requested
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_reg <= '0;
			s_reg.bus_power_clock_ctrl_enable <= PBC_EN_RESET;
			s_reg.vcc_en <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign PRDATA = s_reg.prdata;
	assign PREADY = s_reg.pready;
	assign PSLVERR = s_reg.pslverr;
	assign SEC_CLK_STOP = s_reg.clk_stop;
	assign SEC_VCC_EN = s_reg.vcc_en;
	assign BUS_STATE = s_reg.bus;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence leave_b0_s;
		s_reg.bus == PBC_B0 ##1 s_reg.bus != PBC_B0;
	endsequence

	sequence settle_exit_s;
		s_reg.bus == PBC_SETTLE ##1
			(s_reg.bus != PBC_SETTLE && s_reg.bus != PBC_B0);
	endsequence

	sequence hot_b3_write_s;
		wr_csr && PWDATA[1:0] == PBC_D3HOT && !hot_off_bus_state_select
			&& s_reg.b3_supported && s_reg.bus_power_clock_ctrl_enable;
	endsequence

	power_loss_b3_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		pwr_lost_s |=> s_reg.bus == PBC_B3 && !SEC_VCC_EN)
		else $error("power loss did not give B3 with supply off");

	settle_first_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		leave_b0_s |-> s_reg.bus == PBC_SETTLE || s_reg.bus == PBC_B3)
		else $error("B0 left without the settle state");

	settle_idle_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		settle_exit_s |-> $past(idle_done) || $past(pwr_lost_s))
		else $error("settle state left before bus was idle");

	hot_off_vcc_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		hot_b3_write_s ##1 (wr_bse == 1'b0 && !wr_csr) [*2]
		|-> ##[0:40] !SEC_VCC_EN)
		else $error("D3hot with B3 did not remove supply");

	clk_stop_low_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		$rose(SEC_CLK_STOP) |-> !$past(clk_s))
		else $error("clock stop requested in the high phase");

	enable_off_run_a: assert property (@(posedge CLOCK)
		disable iff (SYS_RST)
		(!s_reg.bus_power_clock_ctrl_enable && !pwr_lost_s) [*2]
		|-> !SEC_CLK_STOP && SEC_VCC_EN)
		else $error("clock or supply cut with control disabled");

	b2_powered_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_reg.bus == PBC_B2 && !pwr_lost_s |-> SEC_VCC_EN)
		else $error("supply removed in B2");

	d2_cap_zero_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		m66_sec |-> !light_sleep2_supported)
		else $error("Light_sleep2_supported shown on a 66 MHz segment");

	sel_zero_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		m66_both |-> !hot_off_bus_state_select)
		else $error("HOT_OFF_BUS_STATE_SELECT select not zero on 66 MHz bridge");

	b0_running_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_reg.bus == PBC_B0 |-> !SEC_CLK_STOP && SEC_VCC_EN)
		else $error("clock or supply off in B0");

	d1_map_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		(s_reg.power_state_field == PBC_D1 && !pwr_lost_s) [*3]
		|-> ##[0:40] s_reg.bus == PBC_B1)
		else $error("D1 did not map to B1");

	apb_answer_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		apb_access && !PREADY |=> PREADY ##1 !PREADY)
		else $error("APB answer not one wait state and one cycle");

endmodule

`default_nettype wire

// ---- verilog/pbc_hold_timer.sv ----
// Counts cycles for which a condition has held without a break.
// Assumes cond is already in the clock domain.

`timescale 1ns/100ps
`default_nettype none

module pbc_hold_timer #(
	parameter int COUNT = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Condition and result
	input wire logic cond,
	output logic done
);

	localparam int CW = $clog2(COUNT + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic done;
	} pbc_timer_t;

	pbc_timer_t t_reg;
	pbc_timer_t t_next;

	initial begin
		if (COUNT < 1) begin
			$error("pbc_hold_timer: COUNT must be at least 1");
		end
	end

	always_comb begin
		t_next = t_reg;
		if (!cond) begin
			t_next.cnt = '0;
			t_next.done = 1'b0;
		end else if (t_reg.cnt == CW'(COUNT)) begin
			t_next.done = 1'b1;
		end else begin
			t_next.cnt = t_reg.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign done = t_reg.done;

endmodule

`default_nettype wire

// ---- verilog/pbc_sync.sv ----
// Two flip-flop synchroniser for a group of pin levels.
// Assumes inputs are slow levels relative to the system clock.

`timescale 1ns/100ps
`default_nettype none

module pbc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} pbc_sync_t;

	pbc_sync_t s_reg;
	pbc_sync_t s_next;

	initial begin
		if (WIDTH < 1) begin
			$error("pbc_sync: WIDTH must be at least 1");
		end
	end

	always_comb begin
		s_next.meta = d;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.stable;

endmodule

`default_nettype wire
